// [verilog/pbe_pkg.sv]
`default_nettype none
package pbe_pkg;
	// Register indices (byte-wide registers at printed offsets)
	localparam logic [7:0] ADDR_PORT_B_VALUE = 8'h01;
	localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h03;
	localparam logic [7:0] ADDR_PORT_E_VALUE = 8'h08;
	localparam logic [7:0] ADDR_PORT_E_DIRECTION = 8'h09;
	localparam logic [7:0] ADDR_PORT_E_FUNCTION_SELECT = 8'h0a;
	// Function-select field positions
	localparam int BIT_NO_BUS_ENABLE_PIN = 7;
	localparam int BIT_CLOCK_TEST_OUT_ENABLE = 6;
	localparam int BIT_QUEUE_STATUS_OUT_ENABLE = 5;
	localparam int BIT_NO_BUS_CLOCK_OUT = 4;
	localparam int BIT_BYTE_STROBE_ENABLE = 3;
	localparam int BIT_READ_WRITE_PIN_ENABLE = 2;
	localparam int BIT_TRIM_REFERENCE_ENABLE = 1;
	localparam int BIT_STROBE_KIND_SELECT = 0;
	// Mode-dependent reset values of the function-select register
	localparam logic [7:0] RST_SEL_NORMAL_EXPANDED = 8'h00;
	localparam logic [7:0] RST_SEL_SPECIAL = 8'h2c;
	localparam logic [7:0] RST_SEL_PERIPHERAL = 8'hd0;
	localparam logic [7:0] RST_SEL_NORMAL_SINGLE = 8'h90;
	localparam logic [7:0] RST_PORT = 8'h00;
	// Pins of port E that carry pull-ups: 7, 3, 2, 1, 0
	localparam logic [7:0] PULLUP_PIN_MASK = 8'h8f;
	// Operating modes, encoded as {special_n, mode_pin_high, mode_pin_low}
	typedef enum logic [2:0] {
		PBE_SPECIAL_SINGLE = 3'h0,
		PBE_SPECIAL_EXP_NARROW = 3'h1,
		PBE_PERIPHERAL = 3'h2,
		PBE_SPECIAL_EXP_WIDE = 3'h3,
		PBE_NORMAL_SINGLE = 3'h4,
		PBE_NORMAL_EXP_NARROW = 3'h5,
		PBE_RESERVED = 3'h6,
		PBE_NORMAL_EXP_WIDE = 3'h7
	} pbe_mode_t;
endpackage : pbe_pkg
`default_nettype wire

// [verilog/pbe_port_b_e.sv]
// Behaviour
// - Port B I/O single-chip, else address/data bus
// - Port B registers unmapped in expanded/peripheral
// - Direction 0 input, 1 driven output
// - Port E pin alternate function or I/O
// - One bit enables pull-ups on port E input pins 7,3,2,1,0
// - Port E registers unmapped: peripheral, or expanded emulation
// - Port E pins 1,0 never driven, always readable
// - Alternate function overrides direction bit
// - Function-select reset value depends on mode
// - Special expanded resets with bus controls active
// - Normal single-chip resets all port E I/O
// - Peripheral: selector inaccessible, clock test set
// - No-bus-enable bit picks pin 7 function
// - Enable/queue bits write-once normal, skip-first special
// - Clock test bit: never normal, skip-first special
// - Queue status on pins 6,5 in expanded
// - No-bus-clock write rules by single-chip mode
// - Pin 4 bus clock, gated by stretch bit in single-chip
// - Bus clock pin input in peripheral mode
// - Emulation bit lets port E be rebuilt externally
// - Strobe and read/write enables on pins 3,2
// - Strobe-kind bit: bus enable or inverted clock
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pbe_port_b_e (
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire logic [2:0] MODE_I,
	input wire logic PORT_E_EMULATION_I,
	input wire logic IDLE_CLOCK_STRETCH_I,
	input wire logic PULLUP_ENABLE_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	output logic REG_EXTERNAL_O,
	input wire logic [7:0] BUS_ADDR_LO_I,
	input wire logic [7:0] BUS_DATA_LO_I,
	input wire logic BUS_ADDR_PHASE_I,
	input wire logic BUS_DATA_DRIVE_I,
	input wire logic DATA_BUS_ENABLE_N_I,
	input wire logic BUS_CLOCK_I,
	input wire logic LOW_BYTE_STROBE_N_I,
	input wire logic READ_WRITE_I,
	input wire logic QUEUE_STATUS_HI_I,
	input wire logic QUEUE_STATUS_LO_I,
	input wire logic CLOCK_TEST_SIGNAL_I,
	input wire logic TRIM_REFERENCE_I,
	input wire logic [7:0] PORT_B_PIN_I,
	output logic [7:0] PORT_B_PIN_O,
	output logic [7:0] PORT_B_PIN_OE_O,
	input wire logic [7:0] PORT_E_PIN_I,
	output logic [7:0] PORT_E_PIN_O,
	output logic [7:0] PORT_E_PIN_OE_O,
	output logic [7:0] PORT_E_PULLUP_O,
	output logic BUS_CLOCK_IN_O
);
	// =========================================
	// Mode decode
	pbe_pkg::pbe_mode_t mode;
	logic special, single_chip, peripheral, expanded, normal_exp, exp_narrow;
	assign mode = pbe_pkg::pbe_mode_t'(MODE_I);
	assign special = ~MODE_I[2];
	assign single_chip = (MODE_I[1:0] == 2'h0);
	assign peripheral = (mode == pbe_pkg::PBE_PERIPHERAL);
	assign expanded = MODE_I[0];
	assign normal_exp = MODE_I[2] & MODE_I[0];
	assign exp_narrow = (MODE_I[1:0] == 2'h1);

	// =========================================
	// Pin synchronisers: three stages, change taken when stages two and three agree
	logic [7:0] pb_s1, pb_s2, pb_s3, pb_lvl;
	logic [7:0] pe_s1, pe_s2, pe_s3, pe_lvl;
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pb_s1 <= 8'h00;
			pb_s2 <= 8'h00;
			pb_s3 <= 8'h00;
			pe_s1 <= 8'h00;
			pe_s2 <= 8'h00;
			pe_s3 <= 8'h00;
		end else begin
			pb_s1 <= PORT_B_PIN_I;
			pb_s2 <= pb_s1;
			pb_s3 <= pb_s2;
			pe_s1 <= PORT_E_PIN_I;
			pe_s2 <= pe_s1;
			pe_s3 <= pe_s2;
		end
	end
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pb_lvl <= 8'h00;
			pe_lvl <= 8'h00;
		end else begin
			pb_lvl <= (pb_s3 & ~(pb_s2 ^ pb_s3)) | (pb_lvl & (pb_s2 ^ pb_s3));
			pe_lvl <= (pe_s3 & ~(pe_s2 ^ pe_s3)) | (pe_lvl & (pe_s2 ^ pe_s3));
		end
	end

	// =========================================
	// Register file
	logic [7:0] pb_val, pb_dir, pe_val, pe_dir, sel;
	logic init_done, first_seen;
	logic pb_mapped, pe_mapped, sel_mapped;
	logic wr_pb_val, wr_pb_dir, wr_pe_val, wr_pe_dir, wr_sel;
	assign pb_mapped = single_chip;
	assign pe_mapped = ~peripheral & ~(expanded & PORT_E_EMULATION_I);
	assign sel_mapped = ~peripheral;
	assign wr_pb_val = REG_WR_I & pb_mapped & (REG_ADDR_I == pbe_pkg::ADDR_PORT_B_VALUE);
	assign wr_pb_dir = REG_WR_I & pb_mapped & (REG_ADDR_I == pbe_pkg::ADDR_PORT_B_DIRECTION);
	assign wr_pe_val = REG_WR_I & pe_mapped & (REG_ADDR_I == pbe_pkg::ADDR_PORT_E_VALUE);
	assign wr_pe_dir = REG_WR_I & pe_mapped & (REG_ADDR_I == pbe_pkg::ADDR_PORT_E_DIRECTION);
	assign wr_sel = REG_WR_I & sel_mapped &
		(REG_ADDR_I == pbe_pkg::ADDR_PORT_E_FUNCTION_SELECT);

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pb_val <= pbe_pkg::RST_PORT;
			pb_dir <= pbe_pkg::RST_PORT;
			pe_val <= pbe_pkg::RST_PORT;
			pe_dir <= pbe_pkg::RST_PORT;
		end else begin
			if (wr_pb_val) pb_val <= REG_WDATA_I;
			if (wr_pb_dir) pb_dir <= REG_WDATA_I;
			if (wr_pe_val) pe_val <= REG_WDATA_I;
			if (wr_pe_dir) pe_dir <= REG_WDATA_I;
		end
	end

	// The reset value needs the mode, which is a port; it is loaded at the first edge
	// after release, since an async reset may only load constants.
	logic [7:0] sel_reset_value;
	always_comb begin
		case (mode)
			pbe_pkg::PBE_NORMAL_EXP_WIDE, pbe_pkg::PBE_NORMAL_EXP_NARROW:
				sel_reset_value = pbe_pkg::RST_SEL_NORMAL_EXPANDED;
			pbe_pkg::PBE_PERIPHERAL: sel_reset_value = pbe_pkg::RST_SEL_PERIPHERAL;
			pbe_pkg::PBE_NORMAL_SINGLE: sel_reset_value = pbe_pkg::RST_SEL_NORMAL_SINGLE;
			default: sel_reset_value = pbe_pkg::RST_SEL_SPECIAL;
		endcase
	end

	// Per-bit write permission of the function-select register
	logic [7:0] wmask;
	always_comb begin
		wmask = 8'h00;
		wmask[pbe_pkg::BIT_TRIM_REFERENCE_ENABLE] = 1'b1;
		if (special) begin
			// Skip-first bits take every write after the first one
			wmask[pbe_pkg::BIT_NO_BUS_ENABLE_PIN] = first_seen;
			wmask[pbe_pkg::BIT_STROBE_KIND_SELECT] = first_seen;
			wmask[pbe_pkg::BIT_QUEUE_STATUS_OUT_ENABLE] = first_seen;
			wmask[pbe_pkg::BIT_BYTE_STROBE_ENABLE] = first_seen;
			wmask[pbe_pkg::BIT_READ_WRITE_PIN_ENABLE] = first_seen;
			wmask[pbe_pkg::BIT_CLOCK_TEST_OUT_ENABLE] = first_seen;
		end else begin
			wmask[pbe_pkg::BIT_NO_BUS_ENABLE_PIN] = ~first_seen;
			wmask[pbe_pkg::BIT_STROBE_KIND_SELECT] = ~first_seen;
			wmask[pbe_pkg::BIT_QUEUE_STATUS_OUT_ENABLE] = ~first_seen;
			wmask[pbe_pkg::BIT_BYTE_STROBE_ENABLE] = ~first_seen;
			wmask[pbe_pkg::BIT_READ_WRITE_PIN_ENABLE] = ~first_seen;
		end
		if (mode == pbe_pkg::PBE_SPECIAL_SINGLE) begin
			wmask[pbe_pkg::BIT_NO_BUS_CLOCK_OUT] = 1'b1;
		end else if (mode == pbe_pkg::PBE_NORMAL_SINGLE) begin
			wmask[pbe_pkg::BIT_NO_BUS_CLOCK_OUT] = ~first_seen;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sel <= pbe_pkg::RST_SEL_NORMAL_EXPANDED;
			init_done <= 1'b0;
			first_seen <= 1'b0;
		end else if (!init_done) begin
			sel <= sel_reset_value;
			init_done <= 1'b1;
		end else if (wr_sel) begin
			sel <= (sel & ~wmask) | (REG_WDATA_I & wmask);
			first_seen <= 1'b1;
		end
	end

	// =========================================
	// Pin function selection
	logic pe7_bus, pe7_trim, pe6_queue, pe6_test, pe5_queue, pe4_clk, pe3_strobe, pe2_rw;
	assign pe7_bus = expanded & ~sel[pbe_pkg::BIT_NO_BUS_ENABLE_PIN];
	assign pe7_trim = ~pe7_bus & sel[pbe_pkg::BIT_TRIM_REFERENCE_ENABLE];
	assign pe6_queue = expanded & sel[pbe_pkg::BIT_QUEUE_STATUS_OUT_ENABLE];
	assign pe6_test = ~pe6_queue & sel[pbe_pkg::BIT_CLOCK_TEST_OUT_ENABLE] &
		~single_chip & ~normal_exp;
	assign pe5_queue = pe6_queue;
	assign pe4_clk = ~sel[pbe_pkg::BIT_NO_BUS_CLOCK_OUT] &
		(~single_chip | ~IDLE_CLOCK_STRETCH_I);
	assign pe3_strobe = sel[pbe_pkg::BIT_BYTE_STROBE_ENABLE] & ~single_chip &
		~(normal_exp & exp_narrow);
	assign pe2_rw = sel[pbe_pkg::BIT_READ_WRITE_PIN_ENABLE] & ~single_chip;

	logic [7:0] pe_alt, pe_alt_out, pe_alt_in;
	always_comb begin
		pe_alt = {pe7_bus | pe7_trim, pe6_queue | pe6_test, pe5_queue, pe4_clk,
			pe3_strobe, pe2_rw, 2'h0};
		pe_alt_in = 8'h00;
		pe_alt_in[4] = pe4_clk & peripheral;
		pe_alt_out = 8'h00;
		if (pe7_bus) begin
			pe_alt_out[7] = sel[pbe_pkg::BIT_STROBE_KIND_SELECT] ? ~BUS_CLOCK_I :
				DATA_BUS_ENABLE_N_I;
		end else begin
			pe_alt_out[7] = TRIM_REFERENCE_I;
		end
		pe_alt_out[6] = pe6_queue ? QUEUE_STATUS_HI_I : CLOCK_TEST_SIGNAL_I;
		pe_alt_out[5] = QUEUE_STATUS_LO_I;
		pe_alt_out[4] = BUS_CLOCK_I;
		pe_alt_out[3] = LOW_BYTE_STROBE_N_I;
		pe_alt_out[2] = READ_WRITE_I;
		pe_alt_out[1:0] = 2'h0;
	end

	// Effective output enables: alternate function fixes direction, pins 1,0 input only
	logic [7:0] pe_oe, pb_oe;
	assign pe_oe = ((pe_alt & ~pe_alt_in) | (~pe_alt & pe_dir)) & 8'hfc;
	assign pb_oe = single_chip ? pb_dir : 8'h00;

	// =========================================
	// Pin drivers (registered)
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PORT_B_PIN_O <= 8'h00;
			PORT_B_PIN_OE_O <= 8'h00;
		end else if (single_chip) begin
			PORT_B_PIN_O <= pb_val;
			PORT_B_PIN_OE_O <= pb_oe;
		end else if (BUS_ADDR_PHASE_I) begin
			PORT_B_PIN_O <= BUS_ADDR_LO_I;
			PORT_B_PIN_OE_O <= 8'hff;
		end else if (exp_narrow) begin
			// Narrow bus keeps the low address on port B during the data phase
			PORT_B_PIN_O <= BUS_ADDR_LO_I;
			PORT_B_PIN_OE_O <= 8'hff;
		end else begin
			PORT_B_PIN_O <= BUS_DATA_LO_I;
			PORT_B_PIN_OE_O <= {8{BUS_DATA_DRIVE_I}};
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PORT_E_PIN_O <= 8'h00;
			PORT_E_PIN_OE_O <= 8'h00;
			PORT_E_PULLUP_O <= 8'h00;
			BUS_CLOCK_IN_O <= 1'b0;
		end else begin
			PORT_E_PIN_O <= (pe_alt & pe_alt_out) | (~pe_alt & pe_val);
			PORT_E_PIN_OE_O <= pe_oe;
			PORT_E_PULLUP_O <= {8{PULLUP_ENABLE_I}} & ~pe_oe & pbe_pkg::PULLUP_PIN_MASK;
			BUS_CLOCK_IN_O <= pe_lvl[4];
		end
	end

	// =========================================
	// Read path: one cycle latency, unmapped reads return zero; all but the selector flag external
	logic [7:0] next_rdata;
	logic next_external;
	always_comb begin
		next_rdata = 8'h00;
		next_external = 1'b0;
		case (REG_ADDR_I)
			pbe_pkg::ADDR_PORT_B_VALUE: begin
				if (pb_mapped) next_rdata = (pb_dir & pb_val) | (~pb_dir & pb_lvl);
				else next_external = 1'b1;
			end
			pbe_pkg::ADDR_PORT_B_DIRECTION: begin
				if (pb_mapped) next_rdata = pb_dir;
				else next_external = 1'b1;
			end
			pbe_pkg::ADDR_PORT_E_VALUE: begin
				if (pe_mapped) next_rdata = (pe_oe & pe_val) | (~pe_oe & pe_lvl);
				else next_external = 1'b1;
			end
			pbe_pkg::ADDR_PORT_E_DIRECTION: begin
				if (pe_mapped) next_rdata = pe_dir;
				else next_external = 1'b1;
			end
			pbe_pkg::ADDR_PORT_E_FUNCTION_SELECT: begin
				if (sel_mapped) next_rdata = sel;
			end
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			REG_RDATA_O <= 8'h00;
			REG_EXTERNAL_O <= 1'b0;
		end else begin
			REG_RDATA_O <= REG_RD_I ? next_rdata : 8'h00;
			REG_EXTERNAL_O <= (REG_RD_I | REG_WR_I) & next_external;
		end
	end

	// =========================================
	// Checks
	a_pb_hidden_write: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(REG_WR_I && !single_chip && REG_ADDR_I == pbe_pkg::ADDR_PORT_B_VALUE)
		|=> $stable(pb_val)) else $error("port B latch changed while unmapped");
	a_pe_hidden_write: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(REG_WR_I && peripheral && REG_ADDR_I == pbe_pkg::ADDR_PORT_E_DIRECTION)
		|=> $stable(pe_dir)) else $error("port E direction changed while unmapped");
	a_pb_dir_drive: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(single_chip && init_done) |=> (PORT_B_PIN_OE_O == $past(pb_dir)))
		else $error("port B enable does not follow direction");
	a_irq_never_out: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		PORT_E_PIN_OE_O[1:0] == 2'h0) else $error("interrupt pin driven");
	a_sel_reset: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(!init_done && mode == pbe_pkg::PBE_PERIPHERAL) |=> (sel == pbe_pkg::RST_SEL_PERIPHERAL))
		else $error("wrong peripheral reset selection");
	a_ctest_locked: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(init_done && !special) |=> $stable(sel[pbe_pkg::BIT_CLOCK_TEST_OUT_ENABLE]))
		else $error("clock test bit changed in normal mode");
	sequence s_first_sel_write;
		wr_sel && !first_seen && special;
	endsequence
	a_skip_first: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		s_first_sel_write |=> $stable(sel[pbe_pkg::BIT_QUEUE_STATUS_OUT_ENABLE]))
		else $error("first special write took effect");
	a_pullup_inputs: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		((PORT_E_PULLUP_O & PORT_E_PIN_OE_O) == 8'h00))
		else $error("pull-up on driven pin");
	a_clk_pin_in: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(peripheral && init_done) |=> !PORT_E_PIN_OE_O[4]) else $error("clock pin driven");
	a_queue_pins: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(pe6_queue && init_done) |=> (PORT_E_PIN_OE_O[6:5] == 2'h3))
		else $error("queue pins not driven");
	// Alternate functions own their pins whatever the direction register holds
	logic [7:0] alt_drive;
	assign alt_drive = pe_alt & ~pe_alt_in & 8'hfc;
	a_alt_dir_fixed: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		init_done |=> ((PORT_E_PIN_OE_O & $past(alt_drive)) == $past(alt_drive)))
		else $error("alternate function lost its pin");
	a_pe7_bus_enable: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(pe7_bus && !sel[pbe_pkg::BIT_STROBE_KIND_SELECT])
		|=> (PORT_E_PIN_O[7] == $past(DATA_BUS_ENABLE_N_I)))
		else $error("pin 7 does not carry bus enable");
	a_pb_addr_phase: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(!single_chip && BUS_ADDR_PHASE_I) |=> (PORT_B_PIN_O == $past(BUS_ADDR_LO_I)))
		else $error("port B misses low address");
	a_sel_single_reset: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(!init_done && mode == pbe_pkg::PBE_NORMAL_SINGLE) |=> (sel == pbe_pkg::RST_SEL_NORMAL_SINGLE))
		else $error("wrong single-chip reset selection");
	a_sel_special_reset: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(!init_done && special && !peripheral) |=> (sel == pbe_pkg::RST_SEL_SPECIAL))
		else $error("wrong special reset selection");
	sequence s_late_normal_write;
		wr_sel && first_seen && !special;
	endsequence
	a_once_normal: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		s_late_normal_write |=> $stable(sel[pbe_pkg::BIT_QUEUE_STATUS_OUT_ENABLE]))
		else $error("second normal write took effect");
	a_stretch_gate: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(single_chip && IDLE_CLOCK_STRETCH_I) |=> (PORT_E_PIN_OE_O[4] == $past(pe_dir[4])))
		else $error("bus clock on pin 4 while stretched");
	a_pullup_off: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		!PULLUP_ENABLE_I |=> (PORT_E_PULLUP_O == 8'h00))
		else $error("pull-up on while disabled");
	a_read_idle: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		!REG_RD_I |=> (REG_RDATA_O == 8'h00))
		else $error("read data without read strobe");
	a_pe_hidden_read: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(REG_RD_I && !pe_mapped && REG_ADDR_I == pbe_pkg::ADDR_PORT_E_VALUE) |=> REG_EXTERNAL_O)
		else $error("hidden port E read not sent out");
endmodule : pbe_port_b_e
`default_nettype wire

// [test/pbe_bus_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Far side of one port: resolves each pad from every driver
module pbe_bus_partner (
	input wire logic clk_i,
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	input wire logic [7:0] pullup_i,
	input wire logic [7:0] ext_oe_i,
	input wire logic [7:0] ext_val_i,
	output logic [7:0] pin_i_o
);
	logic [7:0] last = 8'h00;
	// A floating pad without pull-up toggles so stale data never reads as valid
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_i_o[i] = pin_oe_i[i] ? pin_o_i[i] : ext_oe_i[i] ? ext_val_i[i] : pullup_i[i] | ~last[i];
		end
	end
	always @(posedge clk_i) begin
		last <= pin_i_o;
	end
endmodule : pbe_bus_partner
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0, nrst = 1'b0, emu = 1'b0, stretch = 1'b0, pu_en = 1'b0;
	logic wr_s = 1'b0, rd_s = 1'b0, aph = 1'b0, ddrv = 1'b0, ext, bcin, x;
	logic [2:0] mode = 3'h4;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, bal = 8'h00, bdl = 8'h00, alt = 8'h00;
	logic [7:0] pbi, pbo, pboe, pei, peo, peoe, pepu, b_val = 8'h00, e_val = 8'h00, d, v, p, k, sel;
	int fails = 0, compares = 0, seed;
	bit seen;
	logic [2:0] mlist [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
	always #50 clk = ~clk;
	pbe_port_b_e u_pbe_port_b_e (.SYS_CLK_I(clk), .NRST_I(nrst), .MODE_I(mode),
		.PORT_E_EMULATION_I(emu), .IDLE_CLOCK_STRETCH_I(stretch), .PULLUP_ENABLE_I(pu_en),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
		.REG_RDATA_O(rdata), .REG_EXTERNAL_O(ext), .BUS_ADDR_LO_I(bal), .BUS_DATA_LO_I(bdl),
		.BUS_ADDR_PHASE_I(aph), .BUS_DATA_DRIVE_I(ddrv), .DATA_BUS_ENABLE_N_I(alt[7]),
		.BUS_CLOCK_I(alt[6]), .LOW_BYTE_STROBE_N_I(alt[5]), .READ_WRITE_I(alt[4]),
		.QUEUE_STATUS_HI_I(alt[3]), .QUEUE_STATUS_LO_I(alt[2]), .CLOCK_TEST_SIGNAL_I(alt[1]),
		.TRIM_REFERENCE_I(alt[0]), .PORT_B_PIN_I(pbi), .PORT_B_PIN_O(pbo),
		.PORT_B_PIN_OE_O(pboe), .PORT_E_PIN_I(pei), .PORT_E_PIN_O(peo),
		.PORT_E_PIN_OE_O(peoe), .PORT_E_PULLUP_O(pepu), .BUS_CLOCK_IN_O(bcin));
	pbe_bus_partner u_pb_far (.clk_i(clk), .pin_o_i(pbo), .pin_oe_i(pboe), .pullup_i(8'h00),
		.ext_oe_i(8'hff), .ext_val_i(b_val), .pin_i_o(pbi));
	pbe_bus_partner u_pe_far (.clk_i(clk), .pin_o_i(peo), .pin_oe_i(peoe), .pullup_i(pepu),
		.ext_oe_i(8'hff), .ext_val_i(e_val), .pin_i_o(pei));
	// ==========
	// Bench model of the function selector
	function automatic logic [7:0] rst_sel(input logic [2:0] m);
		case (m)
			3'h2: return 8'h00;
			3'h4: return pbe_pkg::RST_SEL_NORMAL_SINGLE;
			3'h5, 3'h7: return pbe_pkg::RST_SEL_NORMAL_EXPANDED;
			default: return pbe_pkg::RST_SEL_SPECIAL;
		endcase
	endfunction : rst_sel
	function automatic logic [7:0] wmask(input logic [2:0] m, input bit s);
		logic [7:0] r;
		r = 8'h02;
		if (m == 3'h2) return 8'h00;
		if (m[2]) r = r | (s ? 8'h00 : (m == 3'h4 ? 8'hbd : 8'had));
		else r = r | (s ? 8'hed : 8'h00) | (m == 3'h0 ? 8'h10 : 8'h00);
		return r;
	endfunction : wmask
	// ==========
	// Bus cycles and comparison
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		@(posedge clk);
		addr <= a;
		wdata <= dv;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] dv, output logic xv);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		// The answer stands for one cycle; it is taken at that cycle's closing edge
		@(posedge clk);
		dv = rdata;
		xv = ext;
	endtask : rd
	task automatic do_reset(input logic [2:0] m);
		@(posedge clk);
		nrst <= 1'b0;
		mode <= m;
		alt <= 8'($urandom);
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : do_reset
	task automatic wrap_up();
		if (fails == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// ==========
	// Watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#500000;
		fails++;
		wrap_up();
	end
	initial begin
		seed = $urandom(32'h46fd5afa);
		foreach (mlist[j]) begin
			do_reset(mlist[j]);
			rd(pbe_pkg::ADDR_PORT_E_FUNCTION_SELECT, d, x);
			chk("sel_reset", rst_sel(mlist[j]), d);
			sel = rst_sel(mlist[j]);
			seen = 1'b0;
			repeat (2) begin
				v = 8'($urandom);
				wr(pbe_pkg::ADDR_PORT_E_FUNCTION_SELECT, v);
				k = wmask(mlist[j], seen);
				sel = (sel & ~k) | (v & k);
				seen = 1'b1;
				rd(pbe_pkg::ADDR_PORT_E_FUNCTION_SELECT, d, x);
				chk("sel_write", sel, d);
			end
		end
		// Normal single chip: both ports as plain I/O, then bus clock and trim reference on port E
		do_reset(3'h4);
		b_val <= 8'($urandom);
		e_val <= 8'($urandom);
		pu_en <= 1'b1;
		v = 8'($urandom);
		p = 8'($urandom);
		wr(pbe_pkg::ADDR_PORT_B_DIRECTION, v);
		wr(pbe_pkg::ADDR_PORT_B_VALUE, p);
		wr(pbe_pkg::ADDR_PORT_E_DIRECTION, v);
		wr(pbe_pkg::ADDR_PORT_E_VALUE, p);
		repeat (8) @(posedge clk);
		chk("pb_oe", v, pboe);
		chk("pb_out", p & v, pbo & v);
		chk("pe_oe", v & 8'hfc, peoe);
		chk("pe_pullup", ~(v & 8'hfc) & pbe_pkg::PULLUP_PIN_MASK, pepu);
		rd(pbe_pkg::ADDR_PORT_B_VALUE, d, x);
		chk("pb_read", (v & p) | (~v & b_val), d);
		rd(pbe_pkg::ADDR_PORT_E_VALUE, d, x);
		chk("pe_read", (v & 8'hfc & p) | (~(v & 8'hfc) & e_val), d);
		wr(pbe_pkg::ADDR_PORT_E_FUNCTION_SELECT, 8'h82);
		repeat (3) @(posedge clk);
		chk("pe4_clk", {7'h0, alt[6]}, {7'h0, peo[4] & peoe[4]});
		chk("pe7_trim", {7'h0, alt[0]}, {7'h0, peo[7] & peoe[7]});
		stretch <= 1'b1;
		repeat (3) @(posedge clk);
		chk("pe4_stretch", {7'h0, v[4]}, {7'h0, peoe[4]});
		stretch <= 1'b0;
		// Normal expanded wide: bus on port B, strobes enabled by software
		do_reset(3'h7);
		rd(pbe_pkg::ADDR_PORT_B_VALUE, d, x);
		chk("pb_unmapped", 8'h01, {7'h0, x});
		wr(pbe_pkg::ADDR_PORT_B_VALUE, 8'hff);
		rd(pbe_pkg::ADDR_PORT_E_VALUE, d, x);
		chk("pe_mapped", 8'h00, {7'h0, x});
		emu <= 1'b1;
		rd(pbe_pkg::ADDR_PORT_E_DIRECTION, d, x);
		chk("pe_emulated", 8'h01, {7'h0, x});
		emu <= 1'b0;
		aph <= 1'b1;
		bal <= 8'($urandom);
		repeat (3) @(posedge clk);
		chk("pb_addr", bal, pbo & pboe);
		chk("pe4_out", 8'h01, {7'h0, peoe[4]});
		aph <= 1'b0;
		ddrv <= 1'b1;
		bdl <= 8'($urandom);
		wr(pbe_pkg::ADDR_PORT_E_FUNCTION_SELECT, 8'h0d);
		repeat (3) @(posedge clk);
		chk("pb_data", bdl, pbo & pboe);
		chk("pe7_clk_n", {7'h0, ~alt[6]}, {7'h0, peo[7] & peoe[7]});
		chk("pe_strobes", {6'h0, alt[5], alt[4]}, {6'h0, peo[3:2] & peoe[3:2]});
		// Narrow expanded: address stays on port B in the data phase
		do_reset(3'h5);
		repeat (3) @(posedge clk);
		chk("pb_narrow", bal, pbo & pboe);
		// Special expanded wide: bus controls and queue status from reset
		do_reset(3'h3);
		repeat (3) @(posedge clk);
		chk("pe_ctrl_oe", 8'h1f, {3'h0, peoe[6:2]});
		chk("pe_queue", {6'h0, alt[3], alt[2]}, {6'h0, peo[6:5]});
		chk("pe7_dbe", {7'h0, alt[7]}, {7'h0, peo[7] & peoe[7]});
		// Peripheral: bus clock is an input, clock test on pin 6
		do_reset(3'h2);
		repeat (8) @(posedge clk);
		chk("pe4_in", {7'h0, e_val[4]}, {6'h0, peoe[4], bcin});
		chk("pe6_test", {7'h0, alt[1]}, {7'h0, peo[6] & peoe[6]});
		wr(pbe_pkg::ADDR_PORT_E_DIRECTION, 8'hff);
		rd(pbe_pkg::ADDR_PORT_B_DIRECTION, d, x);
		chk("pb_periph", 8'h01, {7'h0, x});
		rd(pbe_pkg::ADDR_PORT_E_VALUE, d, x);
		chk("pe_periph", 8'h01, {7'h0, x});
		chk("pe_dir_hidden", 8'h40, peoe);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
